// ---- shared/pmfc_defs.vh ----
// constants for the port merge and upstream failover controller
// assumes a 200 MHz core clock and a 32-bit AXI4-Lite register port
`ifndef PMFC_DEFS_VH
`define PMFC_DEFS_VH

// ----------------------------------------
// port geometry
// ----------------------------------------
`define PMFC_NUM_PORTS 12
`define PMFC_NUM_PAIRS 6
`define PMFC_LANES 4
`define PMFC_SIDE_W 4
`define PMFC_ADDR_W 8

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PMFC_OFF_SW_CONTROL 8'h00
`define PMFC_OFF_FO_CONTROL 8'h04
`define PMFC_OFF_FO_STATUS 8'h08
`define PMFC_OFF_PORT_CFG 8'h0c
`define PMFC_OFF_LINK_CAP0 8'h40
`define PMFC_OFF_LINK_CAP11 8'h6c

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define PMFC_BIT_LD_HR_DIS 0
`define PMFC_BIT_SIG_FO_EN 0
`define PMFC_BIT_FO_ENABLED 0
`define PMFC_BIT_CUR_UP 1
`define PMFC_BIT_UP_CHANGE 2
`define PMFC_BIT_FO_BUSY 3
`define PMFC_PCFG_EN_LSB 0
`define PMFC_PCFG_MERGE_LSB 12
`define PMFC_PCFG_MODE_LSB 20
`define PMFC_LCAP_MLW_LSB 4
`define PMFC_MLW_X4 6'h04
`define PMFC_MLW_X8 6'h08
`define PMFC_RESP_OKAY 2'h0
`define PMFC_RESP_DECERR 2'h3

// ----------------------------------------
// switch mode strap codes that enable failover
// ----------------------------------------
`define PMFC_MODE_FO_P0 4'h8
`define PMFC_MODE_FO_P2 4'h9
`define PMFC_MODE_FO_EE_P0 4'ha
`define PMFC_MODE_FO_EE_P2 4'hb

// ----------------------------------------
// timing
// ----------------------------------------
`define PMFC_CLK_PERIOD_NS 5
`define PMFC_LINK_DOWN_NS 100
`define PMFC_LINK_DOWN_CYC ((`PMFC_LINK_DOWN_NS + `PMFC_CLK_PERIOD_NS - 1) / `PMFC_CLK_PERIOD_NS)

`endif

// ---- verification/pmfc_link_partner.sv ----
// link partner model: the root and downstream devices seen at the pins
// assumes one partner per port, each sending a fixed lane pattern
`timescale 1ns/1ps

module pmfc_link_partner (
	output logic [47:0] pin_rx_lanes,
	output logic [47:0] pin_port_in
);
	// each port sends its own nibble so that lane routing can be traced
	assign pin_rx_lanes = 48'hcba987654321;
	// sideband inputs sit at their pulled-up level
	assign pin_port_in = 48'hffffffffffff;
endmodule

// ---- verification/pmfc_port_ctrl_assertions.sv ----
// checker for the port merge and upstream failover controller
// assumes it is bound to pmfc_port_ctrl and sees only its ports
`timescale 1ns/1ps

module pmfc_port_ctrl_assertions (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire cfg_req_valid,
	input wire [3:0] cfg_req_dev,
	input wire cfg_req_ur,
	input wire [11:0] port_enabled,
	input wire [47:0] pin_port_out,
	input wire [47:0] core_port_in,
	input wire upstream_on_port2,
	input wire ltssm_to_detect,
	input wire dl_down,
	input wire flush_upstream,
	input wire hot_reset_req,
	input wire train_start,
	input wire failover_busy
);
	logic [47:0] en_mask;
	logic [5:0] ld_cnt;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	// spread each port enable over its four sideband bits
	always_comb
	begin
		for (int k = 0; k < 12; k++)
			en_mask[4*k +: 4] = {4{port_enabled[k]}};
	end
	// length of the current link-down stretch
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ld_cnt <= 6'h00;
		else if (ltssm_to_detect)
			ld_cnt <= ld_cnt + 6'h01;
		else
			ld_cnt <= 6'h00;
	end

	// ----------------------------------------
	// failover steps
	// ----------------------------------------
	sequence link_down_hold;
		(ltssm_to_detect && dl_down && flush_upstream) [*8];
	endsequence
	sequence flip_and_train;
		$changed(upstream_on_port2) && train_start;
	endsequence

	cfg_ur_a: assert property (cfg_req_valid |->
		cfg_req_ur == (cfg_req_dev > 4'hb || !port_enabled[cfg_req_dev]))
		else $error("config answer wrong");
	out_quiet_a: assert property ($stable(port_enabled) |->
		(pin_port_out & ~en_mask) == 48'h0)
		else $error("disabled port output active");
	in_ignored_a: assert property ($stable(port_enabled) |->
		(core_port_in & ~en_mask) == 48'h0)
		else $error("disabled port input passed");
	busy_p2_off_a: assert property (failover_busy |-> !port_enabled[2])
		else $error("port 2 enabled in failover");
	link_down_a: assert property ($rose(failover_busy) |-> link_down_hold)
		else $error("link down not entered");
	down_len_a: assert property ($fell(ltssm_to_detect) |-> ld_cnt == 6'd20)
		else $error("link down length wrong");
	flip_train_a: assert property ($fell(ltssm_to_detect) |-> ##1 flip_and_train)
		else $error("no flip then train");
	hot_reset_a: assert property (hot_reset_req |-> ltssm_to_detect && failover_busy)
		else $error("hot reset outside failover");
	train_pulse_a: assert property (train_start |=> !train_start)
		else $error("train start too long");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule

bind pmfc_port_ctrl pmfc_port_ctrl_assertions i_pmfc_port_ctrl_assertions (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .cfg_req_valid(cfg_req_valid), .cfg_req_dev(cfg_req_dev),
	.cfg_req_ur(cfg_req_ur), .port_enabled(port_enabled), .pin_port_out(pin_port_out),
	.core_port_in(core_port_in), .upstream_on_port2(upstream_on_port2),
	.ltssm_to_detect(ltssm_to_detect), .dl_down(dl_down), .flush_upstream(flush_upstream),
	.hot_reset_req(hot_reset_req), .train_start(train_start), .failover_busy(failover_busy));

// ---- verification/port_merge_failover_ctrl_bench.sv ----
// testbench for the port merge and upstream failover controller
// assumes a 200 MHz clock and register access over AXI4-Lite
`timescale 1ns/1ps

module port_merge_failover_ctrl_bench;
	logic aclk = 0, aresetn = 0, clk_en = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic sel = 0, foreq = 0, cfgv = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	logic [5:0] merge = 0;
	logic [3:0] mode = 0, dev = 0;
	logic [47:0] cout = 48'h5a5a5a5a5a5a, ctx = 48'h3c3c3c3c3c3c;
	wire awr, wr, bv, arr, rv, ur, up2, ltd, dld, fl, hr, ts, busy;
	wire [1:0] br, rr;
	wire [31:0] rd;
	wire [47:0] pin_in, cin, pout, prx, crx, ptx;
	wire [11:0] pen;
	wire [5:0] pm;
	int n_mismatch = 0, check_count = 0;

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end

	always #2.5 aclk = ~aclk;

	pmfc_port_ctrl i_pmfc_port_ctrl (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rre), .pair_merge_strap(merge), .switch_mode_strap(mode),
		.upstream_select_signal(sel), .failover_req(foreq), .pin_port_in(pin_in),
		.core_port_in(cin), .core_port_out(cout), .pin_port_out(pout), .pin_rx_lanes(prx),
		.core_rx_lanes(crx), .core_tx_lanes(ctx), .pin_tx_lanes(ptx), .cfg_req_valid(cfgv),
		.cfg_req_dev(dev), .cfg_req_ur(ur), .port_enabled(pen), .pair_merged(pm),
		.upstream_on_port2(up2), .ltssm_to_detect(ltd), .dl_down(dld), .flush_upstream(fl),
		.hot_reset_req(hr), .train_start(ts), .failover_busy(busy));
	pmfc_link_partner i_pmfc_link_partner (.pin_rx_lanes(prx), .pin_port_in(pin_in));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task summarize;
	begin
		$display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	// a wait that ran out ends the run
	task tmo;
	begin
		n_mismatch++;
		$display("wrong value at %0t: wait timed out", $time);
		summarize;
	end
	endtask
	// fundamental reset with the given straps, held five cycles
	task boot(input [5:0] m, input [3:0] md);
	begin
		aresetn <= 0;
		merge <= m;
		mode <= md;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		repeat (3) @(posedge aclk);
	end
	endtask
	// one write; address and data offered together, bready held for the answer
	task axw(input [7:0] a, input [31:0] d, input [1:0] er);
		int i;
	begin
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bre <= 1;
		for (i = 0; i < 64; i++)
		begin
			@(posedge aclk);
			if (awr)
				awv <= 0;
			if (wr)
				wv <= 0;
			if (bv)
				break;
		end
		bre <= 0;
		if (i == 64)
			tmo;
		`CHK(br, er)
		// one idle edge so a following call never re-raises bready in this step
		@(posedge aclk);
	end
	endtask
	// one read; data judged only on an okay answer
	task axr(input [7:0] a, input [31:0] ed, input [1:0] er);
		int i;
	begin
		ara <= a;
		arv <= 1;
		rre <= 1;
		for (i = 0; i < 64; i++)
		begin
			@(posedge aclk);
			if (arr)
				arv <= 0;
			if (rv)
				break;
		end
		rre <= 0;
		if (i == 64)
			tmo;
		`CHK(rr, er)
		if (er == 2'h0)
			`CHK(rd, ed)
		// one idle edge so a following call never re-raises rready in this step
		@(posedge aclk);
	end
	endtask
	// count link-down, hot reset and training cycles over one failover window
	task fo_run(output int nl, output int nh, output int nt);
	begin
		nl = 0;
		nh = 0;
		nt = 0;
		repeat (40)
		begin
			@(posedge aclk);
			foreq <= 0;
			nl += int'(ltd);
			nh += int'(hr);
			nt += int'(ts);
		end
		`CHK(busy, 1'b0)
	end
	endtask
	// every device number against the expected unsupported-request answer
	task cfg_chk(input [11:0] en);
	begin
		for (int d = 0; d < 16; d++)
		begin
			cfgv <= 1;
			dev <= 4'(d);
			@(posedge aclk);
			`CHK(ur, (d > 11 || !en[d]))
		end
		cfgv <= 0;
	end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// pairs 0 and 4 merged in normal mode; failover controls must stay inert
	task s_merge;
		int nl, nh, nt;
	begin
		boot(6'h11, 4'h0);
		`CHK(pen, 12'hdfd)
		`CHK(pm, 6'h11)
		`CHK(pout, cout & 48'hff0fffffff0f)
		`CHK(cin, pin_in & 48'hff0fffffff0f)
		`CHK(crx[7:0], prx[7:0])
		cfg_chk(12'hdfd);
		axr(8'h40, 32'h80, 2'h0);
		axr(8'h44, 32'h0, 2'h0);
		axr(8'h48, 32'h40, 2'h0);
		axw(8'h0c, 32'h0, 2'h0);
		axr(8'h0c, 32'h00011dfd, 2'h0);
		axw(8'h10, 32'h1, 2'h3);
		axr(8'h10, 32'h0, 2'h3);
		axr(8'h08, 32'h0, 2'h0);
		axw(8'h04, 32'h1, 2'h0);
		sel <= 1;
		foreq <= 1;
		fo_run(nl, nh, nt);
		`CHK(nl, 0)
		`CHK(up2, 1'b0)
		sel <= 0;
	end
	endtask
	// every failover mode and one normal code
	task s_modes;
		int cd[5] = '{7, 8, 9, 10, 11};
		int st[5] = '{0, 1, 3, 1, 3};
	begin
		for (int k = 0; k < 5; k++)
		begin
			boot(6'h0, 4'(cd[k]));
			axr(8'h08, 32'(st[k]), 2'h0);
			`CHK(pen, (cd[k] > 7) ? 12'hffb : 12'hfff)
			`CHK(crx[3:0], (st[k] > 1) ? prx[11:8] : prx[3:0])
			`CHK(pout[3:0], cout[3:0])
		end
	end
	endtask
	// request failover with hot reset off, then signal failover back with it on
	task s_dyn;
		int nl, nh, nt;
	begin
		boot(6'h0, 4'h8);
		axw(8'h00, 32'h1, 2'h0);
		foreq <= 1;
		fo_run(nl, nh, nt);
		`CHK(nl, 20)
		`CHK(nh, 0)
		`CHK(nt, 1)
		`CHK(up2, 1'b1)
		axr(8'h08, 32'h7, 2'h0);
		`CHK(crx[3:0], prx[11:8])
		`CHK(ptx[11:8], ctx[3:0])
		`CHK(ptx[3:0], 4'h0)
		`CHK(pout[11:0], ({4'h0, cout[7:0]}))
		`CHK(pen, 12'hffb)
		axw(8'h08, 32'h4, 2'h0);
		axr(8'h08, 32'h3, 2'h0);
		axw(8'h00, 32'h0, 2'h0);
		sel <= 1;
		axw(8'h04, 32'h1, 2'h0);
		sel <= 0;
		fo_run(nl, nh, nt);
		`CHK(nh, 20)
		`CHK(up2, 1'b0)
		axr(8'h08, 32'h5, 2'h0);
	end
	endtask
	// x8 upstream starting on port 2; board straps both pairs alike
	task s_x8;
		int nl, nh, nt;
	begin
		boot(6'h03, 4'hb);
		`CHK(pen, 12'hff1)
		`CHK(pm, 6'h01)
		`CHK(up2, 1'b1)
		`CHK(crx[7:0], prx[15:8])
		axr(8'h40, 32'h80, 2'h0);
		cfg_chk(12'hff1);
		foreq <= 1;
		fo_run(nl, nh, nt);
		`CHK(up2, 1'b0)
		`CHK(crx[7:0], prx[7:0])
	end
	endtask

	// main sequence
	initial
	begin
		s_merge;
		s_modes;
		s_dyn;
		s_x8;
		summarize;
	end
endmodule

// ---- verilog/pmfc_axil_slave.v ----
// AXI4-Lite slave front end: turns bus transfers into register strobes
// assumes the owner answers rd_data/rd_ok and wr_ok in the strobe cycle
`timescale 1ns/1ps
`include "pmfc_defs.vh"

module pmfc_axil_slave (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire [`PMFC_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`PMFC_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire wr_en,
	output wire [`PMFC_ADDR_W-1:0] wr_addr,
	output wire [31:0] wr_data,
	output wire [3:0] wr_strb,
	input wire wr_ok,
	output wire rd_en,
	output wire [`PMFC_ADDR_W-1:0] rd_addr,
	input wire [31:0] rd_data,
	input wire rd_ok
);

reg aw_full_reg;
reg w_full_reg;
reg [`PMFC_ADDR_W-1:0] awaddr_reg;
reg [31:0] wdata_reg;
reg [3:0] wstrb_reg;

// address and data are held separately, so they may come in either order
assign s_axi_awready = clk_en && !aw_full_reg && !s_axi_bvalid;
assign s_axi_wready = clk_en && !w_full_reg && !s_axi_bvalid;
assign s_axi_arready = clk_en && !s_axi_rvalid;

// write strobe fires once both halves are held and no response is pending
assign wr_en = clk_en && aw_full_reg && w_full_reg && !s_axi_bvalid;
assign wr_addr = awaddr_reg;
assign wr_data = wdata_reg;
assign wr_strb = wstrb_reg;
assign rd_en = s_axi_arvalid && s_axi_arready;
assign rd_addr = s_axi_araddr;

// ----------------------------------------
// write channels
// ----------------------------------------
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		aw_full_reg <= 1'b0;
		w_full_reg <= 1'b0;
		awaddr_reg <= {`PMFC_ADDR_W{1'b0}};
		wdata_reg <= 32'h00000000;
		wstrb_reg <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `PMFC_RESP_OKAY;
	end
	else if (clk_en)
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_full_reg <= 1'b1;
			awaddr_reg <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_full_reg <= 1'b1;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end
		if (wr_en)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `PMFC_RESP_OKAY : `PMFC_RESP_DECERR;
		end
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end
end

// ----------------------------------------
// read channels
// ----------------------------------------
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `PMFC_RESP_OKAY;
	end
	else if (clk_en)
	begin
		if (rd_en)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_ok ? `PMFC_RESP_OKAY : `PMFC_RESP_DECERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
end

endmodule

// ---- verilog/pmfc_port_ctrl.v ----
// port merge, port disable and upstream failover control of a 12-port x4 switch
// assumes straps are stable while aresetn is low and core-side signals are synchronous
`timescale 1ns/1ps
`include "pmfc_defs.vh"

module pmfc_port_ctrl (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire [`PMFC_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`PMFC_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [`PMFC_NUM_PAIRS-1:0] pair_merge_strap,
	input wire [3:0] switch_mode_strap,
	input wire upstream_select_signal,
	input wire failover_req,
	input wire [47:0] pin_port_in,
	output reg [47:0] core_port_in,
	input wire [47:0] core_port_out,
	output reg [47:0] pin_port_out,
	input wire [47:0] pin_rx_lanes,
	output reg [47:0] core_rx_lanes,
	input wire [47:0] core_tx_lanes,
	output reg [47:0] pin_tx_lanes,
	input wire cfg_req_valid,
	input wire [3:0] cfg_req_dev,
	output wire cfg_req_ur,
	output reg [`PMFC_NUM_PORTS-1:0] port_enabled,
	output reg [`PMFC_NUM_PAIRS-1:0] pair_merged,
	output wire upstream_on_port2,
	output wire ltssm_to_detect,
	output wire dl_down,
	output wire flush_upstream,
	output wire hot_reset_req,
	output wire train_start,
	output wire failover_busy
);

// ----------------------------------------
// state encodings
// ----------------------------------------
localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_DOWN = 4'b0010;
localparam [3:0] ST_SWITCH = 4'b0100;
localparam [3:0] ST_TRAIN = 4'b1000;
localparam integer DOWN_CYC_FULL = `PMFC_LINK_DOWN_CYC;
localparam [7:0] DOWN_CYC = DOWN_CYC_FULL[7:0];

// ----------------------------------------
// functions
// ----------------------------------------
// true for the four switch modes that carry upstream failover
function fo_mode;
	input [3:0] mode;
	begin
		fo_mode = (mode == `PMFC_MODE_FO_P0) || (mode == `PMFC_MODE_FO_P2) ||
			(mode == `PMFC_MODE_FO_EE_P0) || (mode == `PMFC_MODE_FO_EE_P2);
	end
endfunction

// true when the strapped mode starts on port 2
function init_port2;
	input [3:0] mode;
	begin
		init_port2 = (mode == `PMFC_MODE_FO_P2) || (mode == `PMFC_MODE_FO_EE_P2);
	end
endfunction

// link capability register index for an address, bit 4 flags a hit
function [4:0] lcap_decode;
	input [`PMFC_ADDR_W-1:0] addr;
	reg [`PMFC_ADDR_W-1:0] rel;
	begin
		rel = addr - `PMFC_OFF_LINK_CAP0;
		lcap_decode = {1'b0, rel[5:2]};
		if (addr >= `PMFC_OFF_LINK_CAP0 && addr <= `PMFC_OFF_LINK_CAP11 && addr[1:0] == 2'b00)
			lcap_decode = {1'b1, rel[5:2]};
	end
endfunction

// ----------------------------------------
// declarations
// ----------------------------------------
reg straps_latched_reg;
reg [`PMFC_NUM_PAIRS-1:0] merge_strap_reg;
reg [3:0] mode_strap_reg;
reg cur_up_p2_reg;
reg up_change_reg;
reg ld_hr_dis_reg;
reg sig_fo_en_reg;
reg [3:0] state_reg;
reg [3:0] state_next;
reg [7:0] down_cnt_reg;
reg [`PMFC_NUM_PORTS-1:0] mode_dis;
reg [`PMFC_NUM_PAIRS-1:0] merge_eff;
reg [`PMFC_NUM_PORTS-1:0] en_next;
reg [`PMFC_NUM_PORTS-1:0] absorbed;
reg [31:0] rd_data;
reg rd_ok;
reg wr_ok;
reg [4:0] rd_lcap;
reg [4:0] wr_lcap;
wire failover_on;
wire x8_upstream;
wire start_failover;
wire status_clear;
wire wr_en;
wire [`PMFC_ADDR_W-1:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire rd_en;
wire [`PMFC_ADDR_W-1:0] rd_addr;
integer k;
integer j;

// ----------------------------------------
// register bus front end
// ----------------------------------------
pmfc_axil_slave u_bus (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.wr_en(wr_en),
	.wr_addr(wr_addr),
	.wr_data(wr_data),
	.wr_strb(wr_strb),
	.wr_ok(wr_ok),
	.rd_en(rd_en),
	.rd_addr(rd_addr),
	.rd_data(rd_data),
	.rd_ok(rd_ok)
);

// ----------------------------------------
// strap capture
// ----------------------------------------
// straps are taken on the first enabled edge after reset release and then frozen
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		straps_latched_reg <= 1'b0;
		merge_strap_reg <= 6'h00;
		mode_strap_reg <= 4'h0;
	end
	else if (clk_en && !straps_latched_reg)
	begin
		straps_latched_reg <= 1'b1;
		merge_strap_reg <= pair_merge_strap;
		mode_strap_reg <= switch_mode_strap;
	end
end

assign failover_on = straps_latched_reg && fo_mode(mode_strap_reg);
assign x8_upstream = merge_strap_reg[0];

// ----------------------------------------
// port enable and merge decode
// ----------------------------------------
always @*
begin
	mode_dis = 12'h000;
	if (failover_on)
	begin
		mode_dis[2] = 1'b1;
		mode_dis[3] = x8_upstream;
	end
	// a strap belonging to a disabled port has no effect
	merge_eff = merge_strap_reg & {6{straps_latched_reg}};
	for (k = 1; k < `PMFC_NUM_PAIRS; k = k + 1)
		merge_eff[k] = merge_eff[k] && !mode_dis[2*k] && !mode_dis[2*k+1];
	for (k = 0; k < `PMFC_NUM_PORTS; k = k + 1)
	begin
		absorbed[k] = k[0] && merge_eff[k/2];
		en_next[k] = straps_latched_reg && !mode_dis[k] && !absorbed[k];
	end
	en_next[0] = straps_latched_reg;
end

// ----------------------------------------
// sideband and lane routing
// ----------------------------------------
// every pin path is registered; the upstream stack sits in slot 0
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		port_enabled <= 12'h000;
		pair_merged <= 6'h00;
		core_port_in <= 48'h000000000000;
		pin_port_out <= 48'h000000000000;
		core_rx_lanes <= 48'h000000000000;
		pin_tx_lanes <= 48'h000000000000;
	end
	else if (clk_en)
	begin
		port_enabled <= en_next;
		pair_merged <= merge_eff;
		for (j = 0; j < `PMFC_NUM_PORTS; j = j + 1)
		begin
			// port 0 sideband always follows slot 0 of the core
			pin_port_out[4*j +: 4] <= en_next[j] ? core_port_out[4*j +: 4] : 4'h0;
			core_port_in[4*j +: 4] <= en_next[j] ? pin_port_in[4*j +: 4] : 4'h0;
			// absorbed lanes stay live as native lanes of the even port
			core_rx_lanes[4*j +: 4] <= (en_next[j] || absorbed[j]) ?
				pin_rx_lanes[4*j +: 4] : 4'h0;
			pin_tx_lanes[4*j +: 4] <= (en_next[j] || absorbed[j]) ?
				core_tx_lanes[4*j +: 4] : 4'h0;
		end
		if (failover_on && cur_up_p2_reg)
		begin
			// stack 0 takes port 2 lanes, and port 3 lanes when x8
			core_rx_lanes[3:0] <= pin_rx_lanes[11:8];
			pin_tx_lanes[11:8] <= core_tx_lanes[3:0];
			pin_tx_lanes[3:0] <= 4'h0;
			if (x8_upstream)
			begin
				core_rx_lanes[7:4] <= pin_rx_lanes[15:12];
				pin_tx_lanes[15:12] <= core_tx_lanes[7:4];
				pin_tx_lanes[7:4] <= 4'h0;
			end
		end
	end
end

// config requests to absent devices end as unsupported
assign cfg_req_ur = cfg_req_valid &&
	((cfg_req_dev >= 4'hc) || !port_enabled[cfg_req_dev]);

// ----------------------------------------
// dynamic failover sequencer
// ----------------------------------------
// a failover_req pulse while busy is dropped, a select signal mismatch waits for idle; controls need failover mode
assign start_failover = failover_on && (state_reg == ST_IDLE) &&
	(failover_req || (sig_fo_en_reg && (upstream_select_signal != cur_up_p2_reg)));

always @*
begin
	case (state_reg)
		ST_IDLE: state_next = start_failover ? ST_DOWN : ST_IDLE;
		ST_DOWN: state_next = (down_cnt_reg == DOWN_CYC - 8'h01) ? ST_SWITCH : ST_DOWN;
		ST_SWITCH: state_next = ST_TRAIN;
		ST_TRAIN: state_next = ST_IDLE;
		default: state_next = ST_IDLE;
	endcase
end

// link is pulled down first, mux moves, then training restarts
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		state_reg <= ST_IDLE;
		down_cnt_reg <= 8'h00;
	end
	else if (clk_en)
	begin
		state_reg <= state_next;
		if (state_reg == ST_DOWN)
			down_cnt_reg <= down_cnt_reg + 8'h01;
		else
			down_cnt_reg <= 8'h00;
	end
end

// link-down indications while the old link is torn down
assign ltssm_to_detect = state_reg[1];
assign dl_down = state_reg[1];
assign flush_upstream = state_reg[1];
assign hot_reset_req = state_reg[1] && !ld_hr_dis_reg;
assign train_start = state_reg[3];
assign failover_busy = !state_reg[0];
assign upstream_on_port2 = cur_up_p2_reg;

// ----------------------------------------
// failover state and control registers
// ----------------------------------------
assign status_clear = wr_en && wr_strb[0] && (wr_addr == `PMFC_OFF_FO_STATUS) &&
	wr_data[`PMFC_BIT_UP_CHANGE];

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		cur_up_p2_reg <= 1'b0;
		up_change_reg <= 1'b0;
		ld_hr_dis_reg <= 1'b0;
		sig_fo_en_reg <= 1'b0;
	end
	else if (clk_en)
	begin
		if (!straps_latched_reg)
			cur_up_p2_reg <= fo_mode(switch_mode_strap) && init_port2(switch_mode_strap);
		else if (state_reg == ST_SWITCH)
			cur_up_p2_reg <= !cur_up_p2_reg;
		// a new change wins over a clear in the same cycle
		if (state_reg == ST_SWITCH)
			up_change_reg <= 1'b1;
		else if (status_clear)
			up_change_reg <= 1'b0;
		if (wr_en && wr_strb[0] && wr_addr == `PMFC_OFF_SW_CONTROL)
			ld_hr_dis_reg <= wr_data[`PMFC_BIT_LD_HR_DIS];
		if (wr_en && wr_strb[0] && wr_addr == `PMFC_OFF_FO_CONTROL)
			sig_fo_en_reg <= wr_data[`PMFC_BIT_SIG_FO_EN];
	end
end

// ----------------------------------------
// register read and write decode
// ----------------------------------------
always @*
begin
	rd_data = 32'h00000000;
	rd_ok = 1'b1;
	rd_lcap = lcap_decode(rd_addr);
	wr_lcap = lcap_decode(wr_addr);
	// link capability registers are read-only; writes are taken and dropped
	wr_ok = (wr_addr == `PMFC_OFF_SW_CONTROL) || (wr_addr == `PMFC_OFF_FO_CONTROL) ||
		(wr_addr == `PMFC_OFF_FO_STATUS) || (wr_addr == `PMFC_OFF_PORT_CFG) || wr_lcap[4];
	case (rd_addr)
		`PMFC_OFF_SW_CONTROL: rd_data[`PMFC_BIT_LD_HR_DIS] = ld_hr_dis_reg;
		`PMFC_OFF_FO_CONTROL: rd_data[`PMFC_BIT_SIG_FO_EN] = sig_fo_en_reg;
		`PMFC_OFF_FO_STATUS:
		begin
			rd_data[`PMFC_BIT_FO_ENABLED] = failover_on;
			rd_data[`PMFC_BIT_CUR_UP] = cur_up_p2_reg;
			rd_data[`PMFC_BIT_UP_CHANGE] = up_change_reg;
			rd_data[`PMFC_BIT_FO_BUSY] = !state_reg[0];
		end
		`PMFC_OFF_PORT_CFG:
		begin
			rd_data[`PMFC_PCFG_EN_LSB +: 12] = port_enabled;
			rd_data[`PMFC_PCFG_MERGE_LSB +: 6] = pair_merged;
			rd_data[`PMFC_PCFG_MODE_LSB +: 4] = mode_strap_reg;
		end
		default:
		begin
			if (rd_lcap[4] && rd_lcap[3:0] < 4'hc)
			begin
				// absent ports read zero; merged even ports report x8
				if (!port_enabled[rd_lcap[3:0]])
					rd_data = 32'h00000000;
				else if (!rd_lcap[0] && pair_merged[rd_lcap[3:1]])
					rd_data[`PMFC_LCAP_MLW_LSB +: 6] = `PMFC_MLW_X8;
				else
					rd_data[`PMFC_LCAP_MLW_LSB +: 6] = `PMFC_MLW_X4;
			end
			else
				rd_ok = 1'b0;
		end
	endcase
end

endmodule
